// [dpbc_aux_ctrl.sv]
// Auxiliary control register with dual data pointers and boot flash mapping.
// How it works
// - Select bit 1 uses second pointer, 0 uses first pointer.
// - Boot enable set maps boot flash over F800h to FFFFh.
// - Boot enable clear leaves ordinary code memory answering everywhere.
// - User flag is plain read/write storage with no hardware effect.
// - Bit 2 always reads zero and ignores writes.
// - Reserved bits read zero; software must not write ones there.
// - Reset clears select bit, loads boot enable from the jump fuse.
// - Incrementing the register toggles the select bit, keeps the user flag.
`timescale 1ns/10ps
`include "dpbc_params.svh"
module dpbc_aux_ctrl
	import dpbc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Strap sampled while reset is held
	input wire logic boot_loader_jump_fuse,
	// Special function register access from the core
	input dpbc_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	// Data pointer operations from the core
	input dpbc_ptr_req_t ptr_req,
	output logic [15:0] dptr_addr,
	// Code fetch mapping
	input wire logic [15:0] code_addr,
	output dpbc_code_sel_t code_sel,
	// Current control bits
	output logic pointer_select,
	output logic boot_flash_map_enable,
	output logic user_flag
);
	dpbc_state_t st_q;
	dpbc_state_t st_d;
	logic aux_hit_wr;
	logic aux_hit_rd;
	logic [7:0] aux_image;

	// Register image as software sees it; reserved positions read as zero.
	function automatic logic [7:0] aux_pack(input dpbc_state_t s);
		logic [7:0] v;
		v = 8'h00;
		v[`DPBC_BIT_PTR_SEL] = s.pointer_select;
		v[`DPBC_BIT_ZERO] = 1'b0;
		v[`DPBC_BIT_USER_FLAG] = s.user_flag;
		v[`DPBC_BIT_BOOT_EN] = s.boot_flash_map_enable;
		return v;
	endfunction

	assign aux_hit_wr = sfr_req.wr && (sfr_req.addr == `DPBC_AUX_ADDR);
	assign aux_hit_rd = sfr_req.rd && (sfr_req.addr == `DPBC_AUX_ADDR);
	assign aux_image = aux_pack(st_q);

	always_comb
	begin
		st_d = st_q;
		// Read data is registered: valid the cycle after the read strobe.
		st_d.rdata = aux_hit_rd ? aux_image : `DPBC_RDATA_IDLE;
		if (aux_hit_wr)
		begin
			// An increment is a read then a write of image plus one. Bits 1 and 2 read
			// zero, so a carry out of bit 0 stops below bit 3 and the user flag survives.
			st_d.pointer_select = sfr_req.wdata[`DPBC_BIT_PTR_SEL];
			st_d.user_flag = sfr_req.wdata[`DPBC_BIT_USER_FLAG];
			st_d.boot_flash_map_enable = sfr_req.wdata[`DPBC_BIT_BOOT_EN];
		end
		// Load wins over increment when the core asserts both.
		if (ptr_req.load)
		begin
			if (st_q.pointer_select)
				st_d.second_data_pointer = ptr_req.load_value;
			else
				st_d.first_data_pointer = ptr_req.load_value;
		end
		else if (ptr_req.inc)
		begin
			if (st_q.pointer_select)
				st_d.second_data_pointer = st_q.second_data_pointer + 16'h0001;
			else
				st_d.first_data_pointer = st_q.first_data_pointer + 16'h0001;
		end
		if (rst)
		begin
			st_d.pointer_select = 1'b0;
			st_d.user_flag = 1'b0;
			// Synchronous reset, so the strap is caught by an ordinary clocked load.
			st_d.boot_flash_map_enable = boot_loader_jump_fuse;
			st_d.first_data_pointer = `DPBC_DPTR_RESET;
			st_d.second_data_pointer = `DPBC_DPTR_RESET;
			st_d.rdata = `DPBC_RDATA_IDLE;
		end
	end

	always_ff @(posedge clk)
	begin
		st_q <= st_d;
	end

	// External moves address through whichever pointer is selected.
	assign dptr_addr = st_q.pointer_select ? st_q.second_data_pointer
		: st_q.first_data_pointer;
	assign sfr_rdata = st_q.rdata;
	assign pointer_select = st_q.pointer_select;
	assign boot_flash_map_enable = st_q.boot_flash_map_enable;
	assign user_flag = st_q.user_flag;

	dpbc_code_map u_code_map
	(
		.code_addr(code_addr),
		.boot_flash_map_enable(st_q.boot_flash_map_enable),
		.sel(code_sel)
	);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_aux_read;
		aux_hit_rd;
	endsequence

	// Software keeps reserved bits at zero, so an increment is matched on the defined bits.
	sequence s_aux_inc_write;
		aux_hit_wr && (((sfr_req.wdata ^ (aux_image + 8'h01)) & `DPBC_DEFINED_BITS) == 8'h00);
	endsequence

	sequence s_load_first;
		ptr_req.load && !st_q.pointer_select;
	endsequence

	sequence s_load_second;
		ptr_req.load && st_q.pointer_select;
	endsequence

	property p_load_second;
		s_load_second |=> (st_q.second_data_pointer == $past(ptr_req.load_value))
			&& $stable(st_q.first_data_pointer);
	endproperty
	a_load_second: assert property (p_load_second) else $error("second pointer load failed");

	property p_load_first;
		s_load_first |=> (st_q.first_data_pointer == $past(ptr_req.load_value))
			&& $stable(st_q.second_data_pointer);
	endproperty
	a_load_first: assert property (p_load_first) else $error("first pointer load failed");

	property p_inc_selected;
		(ptr_req.inc && !ptr_req.load && !aux_hit_wr) |=>
			(dptr_addr == $past(dptr_addr) + 16'h0001);
	endproperty
	a_inc_selected: assert property (p_inc_selected) else $error("pointer increment wrong");

	property p_boot_map;
		(st_q.boot_flash_map_enable && code_addr >= `DPBC_BOOT_BASE) |->
			(code_sel.boot_sel && !code_sel.code_sel);
	endproperty
	a_boot_map: assert property (p_boot_map) else $error("boot window not mapped");

	property p_boot_unmap;
		(!st_q.boot_flash_map_enable || code_addr < `DPBC_BOOT_BASE) |->
			(code_sel.code_sel && !code_sel.boot_sel);
	endproperty
	a_boot_unmap: assert property (p_boot_unmap) else $error("code memory not selected");

	property p_flag_hold;
		!aux_hit_wr |=> $stable(user_flag);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("user flag changed unwritten");

	property p_read_image;
		s_aux_read |=> (sfr_rdata[`DPBC_BIT_ZERO] == 1'b0)
			&& (sfr_rdata[`DPBC_BIT_USER_FLAG] == $past(user_flag))
			&& (sfr_rdata[`DPBC_BIT_PTR_SEL] == $past(pointer_select));
	endproperty
	a_read_image: assert property (p_read_image) else $error("register read image wrong");

	property p_reset_value;
		@(posedge clk) rst |=> !pointer_select && !user_flag
			&& (boot_flash_map_enable == $past(boot_loader_jump_fuse));
	endproperty
	a_reset_value: assert property (disable iff (1'b0) p_reset_value)
		else $error("reset value wrong");

	property p_inc_toggle;
		s_aux_inc_write |=> (pointer_select != $past(pointer_select))
			&& (user_flag == $past(user_flag));
	endproperty
	a_inc_toggle: assert property (p_inc_toggle) else $error("increment did not toggle");

	property p_keep_second;
		(ptr_req.inc && !ptr_req.load && !st_q.pointer_select) |=>
			$stable(st_q.second_data_pointer);
	endproperty
	a_keep_second: assert property (p_keep_second) else $error("unselected pointer moved");

	property p_keep_first;
		(ptr_req.inc && !ptr_req.load && st_q.pointer_select) |=>
			$stable(st_q.first_data_pointer);
	endproperty
	a_keep_first: assert property (p_keep_first) else $error("unselected pointer moved");

	property p_write_bits;
		aux_hit_wr |=>
			(user_flag == $past(sfr_req.wdata[`DPBC_BIT_USER_FLAG]))
			&& (boot_flash_map_enable == $past(sfr_req.wdata[`DPBC_BIT_BOOT_EN]));
	endproperty
	a_write_bits: assert property (p_write_bits) else $error("written bits not held");

	property p_rdata_idle;
		!aux_hit_rd |=> (sfr_rdata == `DPBC_RDATA_IDLE);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

	property p_read_reserved;
		s_aux_read |=> ((sfr_rdata & ~`DPBC_DEFINED_BITS) == 8'h00)
			&& (sfr_rdata[`DPBC_BIT_BOOT_EN] == $past(boot_flash_map_enable));
	endproperty
	a_read_reserved: assert property (p_read_reserved) else $error("bad reserved bits");
endmodule

// [dpbc_code_map.sv]
// Code space decoder that steers fetches to boot flash or ordinary code memory.
`timescale 1ns/10ps
`include "dpbc_params.svh"
module dpbc_code_map
	import dpbc_pkg::*;
(
	// Fetch address and mapping control
	input wire logic [15:0] code_addr,
	input wire logic boot_flash_map_enable,
	// Memory selects
	output dpbc_code_sel_t sel
);
	logic in_boot_window;

	// The window runs to the top of the 64K space; both the lower and the upper bound are compared.
	assign in_boot_window = (code_addr >= `DPBC_BOOT_BASE) && (code_addr <= `DPBC_BOOT_TOP);

	always_comb
	begin
		sel.boot_sel = boot_flash_map_enable && in_boot_window;
		sel.code_sel = !sel.boot_sel;
	end
endmodule

// [dpbc_core_model.sv]
// Core model that issues register accesses and data pointer operations.
`timescale 1ns/10ps
module dpbc_core_model
	import dpbc_pkg::*;
(
	// Clock and read data
	input wire logic clk,
	input wire logic [7:0] sfr_rdata,
	// Requests
	output dpbc_sfr_req_t sfr_req,
	output dpbc_ptr_req_t ptr_req
);
	initial
	begin
		sfr_req = '0;
		ptr_req = '0;
	end

	// A released data bus shows the inverse of the unmasked data d, not a stale copy.
	task automatic sfr_op(input logic [7:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk);
		sfr_req <= '{a, w, !w, d & 8'h2d};
		@(posedge clk);
		sfr_req <= '{8'h00, 1'b0, 1'b0, ~d};
		#1 q = sfr_rdata;
	endtask

	// The increment is a plain read then write of the image plus one.
	task automatic inc_aux();
		logic [7:0] q;
		sfr_op(8'ha2, 1'b0, 8'h00, q);
		sfr_op(8'ha2, 1'b1, q + 8'h01, q);
	endtask

	task automatic ptr_op(input logic l, input logic i, input logic [15:0] v);
		@(posedge clk);
		ptr_req <= '{l, i, v};
		@(posedge clk);
		ptr_req <= '{1'b0, 1'b0, ~v};
		#1;
	endtask
endmodule

// [dpbc_params.svh]
// Constants for the dual pointer and boot mapping control register.
`ifndef DPBC_PARAMS_SVH
`define DPBC_PARAMS_SVH
`define DPBC_AUX_ADDR 8'ha2
`define DPBC_BIT_PTR_SEL 0
`define DPBC_BIT_ZERO 2
`define DPBC_BIT_USER_FLAG 3
`define DPBC_BIT_BOOT_EN 5
`define DPBC_DEFINED_BITS 8'h2d
`define DPBC_BOOT_BASE 16'hf800
`define DPBC_BOOT_TOP 16'hffff
`define DPBC_DPTR_RESET 16'h0000
`define DPBC_RDATA_IDLE 8'h00
`endif

// [dpbc_pkg.sv]
// Types shared by the dual pointer and boot mapping control block.
package dpbc_pkg;
	typedef struct packed
	{
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} dpbc_sfr_req_t;

	typedef struct packed
	{
		logic load;
		logic inc;
		logic [15:0] load_value;
	} dpbc_ptr_req_t;

	typedef struct packed
	{
		logic pointer_select;
		logic user_flag;
		logic boot_flash_map_enable;
		logic [15:0] first_data_pointer;
		logic [15:0] second_data_pointer;
		logic [7:0] rdata;
	} dpbc_state_t;

	typedef struct packed
	{
		logic boot_sel;
		logic code_sel;
	} dpbc_code_sel_t;
endpackage

// [dual_pointer_aux_control_tb_top.sv]
// Self-checking testbench for the auxiliary pointer and boot control register.
`timescale 1ns/10ps
module dual_pointer_aux_control_tb_top
	import dpbc_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic fuse = 1'b1;
	logic [15:0] code_addr = 16'h0000;
	dpbc_sfr_req_t sfr_req;
	dpbc_ptr_req_t ptr_req;
	dpbc_code_sel_t code_sel;
	logic [7:0] sfr_rdata;
	logic [7:0] q;
	logic [15:0] dptr_addr;
	logic pointer_select;
	logic boot_flash_map_enable;
	logic user_flag;
	int miscompares = 0;
	int n_tests = 0;
	logic [15:0] addrs [5] = '{16'hf7ff, 16'hf800, 16'hfa5a, 16'hffff, 16'h0000};
	logic exps [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

	always #25 clk = ~clk;

	dpbc_aux_ctrl dut(.clk(clk), .rst(rst), .boot_loader_jump_fuse(fuse),
		.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .ptr_req(ptr_req),
		.dptr_addr(dptr_addr), .code_addr(code_addr), .code_sel(code_sel),
		.pointer_select(pointer_select), .boot_flash_map_enable(boot_flash_map_enable),
		.user_flag(user_flag));
	dpbc_core_model core(.clk(clk), .sfr_rdata(sfr_rdata), .sfr_req(sfr_req),
		.ptr_req(ptr_req));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic do_reset(input logic f);
		@(posedge clk);
		rst <= 1'b1;
		fuse <= f;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		core.sfr_op(a, 1'b0, 8'h00, q);
		chk(q, exp);
	endtask

	task automatic code_chk(input logic [15:0] a, input logic b);
		@(posedge clk);
		code_addr <= a;
		#1;
		chk({code_sel.boot_sel, code_sel.code_sel}, {b, !b});
	endtask

	initial
	begin
		do_reset(1'b1);
		rd(8'ha2, 8'h20);
		chk(boot_flash_map_enable, 1'b1);
		for (int k = 0; k < 5; k++)
			code_chk(addrs[k], exps[k]);
		do_reset(1'b0);
		rd(8'ha2, 8'h00);
		code_chk(16'hf800, 1'b0);
		code_chk(16'hffff, 1'b0);
		core.sfr_op(8'ha2, 1'b1, 8'h0d, q);
		rd(8'ha2, 8'h09);
		chk({pointer_select, user_flag}, 2'b11);
		core.sfr_op(8'ha3, 1'b1, 8'h00, q);
		rd(8'ha3, 8'h00);
		rd(8'ha2, 8'h09);
		core.ptr_op(1'b1, 1'b0, 16'h1234);
		chk(dptr_addr, 16'h1234);
		core.ptr_op(1'b0, 1'b1, 16'h0000);
		chk(dptr_addr, 16'h1235);
		core.inc_aux();
		chk({pointer_select, user_flag}, 2'b01);
		chk(dptr_addr, 16'h0000);
		core.ptr_op(1'b1, 1'b1, 16'hffff);
		chk(dptr_addr, 16'hffff);
		core.ptr_op(1'b0, 1'b1, 16'h0000);
		chk(dptr_addr, 16'h0000);
		core.inc_aux();
		chk(dptr_addr, 16'h1235);
		chk({pointer_select, user_flag}, 2'b11);
		core.sfr_op(8'ha2, 1'b1, 8'h20, q);
		code_chk(16'hfc00, 1'b1);
		chk(user_flag, 1'b0);
		end_sim();
	end
endmodule
